// ---- pkg/dbl_cyc_if.sv ----
// Carrier between the sequencer and the pin write-cycle engine.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface dbl_cyc_if;
	import dbl_pkg::*;
	logic req;
	logic done;
	dbl_cycle_t cyc;
	modport seq (output req, output cyc, input done);
	modport eng (input req, input cyc, output done);
endinterface
`default_nettype wire

// ---- pkg/dbl_pkg.sv ----
// Package for the byte-load converter host controller.
// Assumes a 10 MHz mclk; all timing counts derive from that rate.
package dbl_pkg;
	// ********************************
	// Clock and pin timing
	// ********************************
	localparam int CLK_NS = 100;
	localparam int T_DS_NS = 230;
	localparam int T_DH_NS = 50;
	localparam int T_CWS_NS = 50;
	localparam int T_CWH_NS = 25;
	localparam int T_WR_NS = 320;
	localparam int SETUP_CYC = (T_CWS_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC_A = (T_DH_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC_B = (T_CWH_NS + CLK_NS - 1) / CLK_NS;
	localparam int HOLD_CYC = HOLD_CYC_A > HOLD_CYC_B ? HOLD_CYC_A : HOLD_CYC_B;
	localparam int WR_A = (T_WR_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_B = (T_DS_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_CYC = WR_A > WR_B ? WR_A : WR_B;
	localparam logic [3:0] SETUP_CNT = 4'(SETUP_CYC);
	localparam logic [3:0] WR_CNT = 4'(WR_CYC);
	localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);

	// ********************************
	// Own register map (word index = address)
	// ********************************
	localparam logic [2:0] A_CTRL = 3'h0;
	localparam logic [2:0] A_CODE = 3'h1;
	localparam logic [2:0] A_CMD = 3'h2;
	localparam logic [2:0] A_STAT = 3'h3;
	localparam logic [2:0] A_LAST = 3'h4;
	// CTRL fields
	localparam int C_RJUST = 0;
	localparam int C_AUTO = 1;
	localparam int C_LOFIRST = 2;
	localparam int C_OVR = 3;
	localparam int C_OVRONES = 4;
	localparam logic [4:0] CTRL_RST = 5'h01;
	// CMD codes
	localparam logic [2:0] CMD_FULL = 3'h1;
	localparam logic [2:0] CMD_HIGH = 3'h2;
	localparam logic [2:0] CMD_LOW = 3'h3;
	localparam logic [2:0] CMD_XFER = 3'h4;
	localparam logic [11:0] CODE_RST = 12'h000;
	localparam logic [7:0] NIB_PAD = 8'h00;

	// One pin cycle request
	typedef struct packed {
		logic sel_high;
		logic sel_low;
		logic load;
		logic [7:0] data;
	} dbl_cycle_t;
endpackage

// ---- sim/dbl_dev_model.sv ----
// Behavioural model of the byte-loaded converter's digital inputs.
// Assumes the host controller drives every pin; no clock of its own.
`timescale 1ns/1ps
`default_nettype none
module dbl_dev_model (
	input wire logic high_byte_select_n,
	input wire logic low_byte_select_n,
	input wire logic dac_load_strobe_n,
	input wire logic wr_n,
	input wire logic [7:0] bus_data,
	input wire logic format_or_override_n,
	input wire logic format_select,
	output logic [11:0] dac_q,
	output logic [11:0] code_out,
	output int writes,
	output int loads
);
	logic [11:0] in_r = 12'h000;
	logic [11:0] dac_r = 12'h000;
	logic armed = 1'b0;
	// Only a rise after a real low counts; power-up unknown to high is none
	always @(negedge wr_n) begin
		armed = 1'b1;
	end
	// Latches close as the write strobe rises, selects still held
	always @(posedge wr_n) begin
		if (armed) begin
			armed = 1'b0;
			writes++;
			if (!high_byte_select_n) begin
				if (format_select)
					in_r[11:8] = bus_data[3:0];
				else
					in_r[11:4] = bus_data;
			end
			if (!low_byte_select_n) begin
				if (format_select)
					in_r[7:0] = bus_data;
				else
					in_r[3:0] = bus_data[7:4];
			end
			if (!dac_load_strobe_n) begin
				dac_r = in_r;
				loads++;
			end
		end
	end
	assign dac_q = dac_r;
	// Override never touches the stored word
	assign code_out = format_or_override_n ? dac_r : {12{format_select}};
endmodule // dbl_dev_model
`default_nettype wire

// ---- sim/dbl_host_checker.sv ----
// Assertions on the pin side of the converter host controller.
// Assumes binding into dbl_host; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module dbl_host_checker
	import dbl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic busy,
	input wire logic high_byte_select_n,
	input wire logic low_byte_select_n,
	input wire logic dac_load_strobe_n,
	input wire logic wr_n,
	input wire logic [7:0] bus_data,
	input wire logic format_or_override_n,
	input wire logic format_select
);
	logic ctl_w;
	logic [10:0] pins;
	assign ctl_w = wr_stb && addr == A_CTRL;
	assign pins = {high_byte_select_n, low_byte_select_n,
		dac_load_strobe_n, bus_data};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_qual; !wr_n |-> busy; endproperty
	a_qual: assert property (p_qual) else $error("stray write");
	property p_width; $fell(wr_n) |-> !wr_n [*4] ##1 wr_n; endproperty
	a_width: assert property (p_width) else $error("pulse width");
	property p_held; (!wr_n || $rose(wr_n)) |-> $stable(pins); endproperty
	a_held: assert property (p_held) else $error("pins moved");
	property p_xfer; !wr_n && high_byte_select_n && low_byte_select_n
		|-> !dac_load_strobe_n; endproperty
	a_xfer: assert property (p_xfer) else $error("empty write");
	property p_norm; !wr_n |-> format_or_override_n; endproperty
	a_norm: assert property (p_norm) else $error("load in override");
	property p_ones; ctl_w && wdata[4:3] == 2'b11
		|-> ##[1:2] !format_or_override_n && format_select; endproperty
	a_ones: assert property (p_ones) else $error("ones override");
	property p_zeros; ctl_w && wdata[4:3] == 2'b01
		|-> ##[1:2] !format_or_override_n && !format_select; endproperty
	a_zeros: assert property (p_zeros) else $error("zeros override");
	property p_rj; ctl_w && !wdata[3] && wdata[0]
		|-> ##[1:2] format_or_override_n && format_select; endproperty
	a_rj: assert property (p_rj) else $error("right format");
	property p_lj; ctl_w && !wdata[3] && !wdata[0]
		|-> ##[1:2] format_or_override_n && !format_select; endproperty
	a_lj: assert property (p_lj) else $error("left format");
	property p_start; wr_stb && addr == A_CMD && wdata[2:0] == CMD_FULL
		&& !busy |-> ##[1:12] $fell(wr_n); endproperty
	a_start: assert property (p_start) else $error("no write");
	c_auto: cover property ($fell(wr_n) && !dac_load_strobe_n
		&& !high_byte_select_n);
	c_xfer: cover property ($fell(wr_n) && high_byte_select_n
		&& low_byte_select_n);
	c_ovr: cover property (!format_or_override_n);
endmodule // dbl_host_checker
bind dbl_host dbl_host_checker i_chk (.mclk(mclk), .rst(rst),
	.addr(addr), .wdata(wdata), .wr_stb(wr_stb), .busy(busy),
	.high_byte_select_n(high_byte_select_n),
	.low_byte_select_n(low_byte_select_n),
	.dac_load_strobe_n(dac_load_strobe_n), .wr_n(wr_n),
	.bus_data(bus_data), .format_or_override_n(format_or_override_n),
	.format_select(format_select));
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench: host controller driving a converter model.
// Assumes one 10 MHz clock and the controller's strobe register port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dbl_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	wire [15:0] rdata;
	wire busy, hs_n, ls_n, ld_n, wr_n, fo_n, fs;
	wire [7:0] bus;
	wire [11:0] dac_q, code_out;
	int writes, loads;
	int fail_count = 0;
	int checks_done = 0;
	dbl_host i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .busy(busy),
		.high_byte_select_n(hs_n), .low_byte_select_n(ls_n),
		.dac_load_strobe_n(ld_n), .wr_n(wr_n), .bus_data(bus),
		.format_or_override_n(fo_n), .format_select(fs));
	dbl_dev_model i_dev (.high_byte_select_n(hs_n),
		.low_byte_select_n(ls_n), .dac_load_strobe_n(ld_n), .wr_n(wr_n),
		.bus_data(bus), .format_or_override_n(fo_n), .format_select(fs),
		.dac_q(dac_q), .code_out(code_out), .writes(writes), .loads(loads));
	always #50 mclk = ~mclk;
	task automatic conclude;
		$display("Checks %0d, mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk);
		wr_stb <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk);
		rd_stb <= 1'b0;
		@(negedge mclk);
		chk(rdata === e, "read data");
	endtask
	// Bounded so a hung sequencer still reaches the report
	task automatic wait_busy(input logic v);
		int n;
		n = 0;
		while (busy !== v) begin
			@(negedge mclk);
			n++;
			if (n > 300) begin
				chk(1'b0, "busy wait ran out");
				conclude();
			end
		end
	endtask
	task automatic run(input logic [2:0] c, input int nw, input int nl);
		int w0;
		int l0;
		w0 = writes;
		l0 = loads;
		wr(A_CMD, {13'h0000, c});
		wait_busy(1'b1);
		wait_busy(1'b0);
		chk(writes - w0 == nw, "write cycle count");
		chk(loads - l0 == nl, "load strobe count");
	endtask
	task automatic s_reset;
		chk(wr_n === 1'b1 && hs_n === 1'b1 && ls_n === 1'b1, "idle pins");
		chk(ld_n === 1'b1 && fo_n === 1'b1 && fs === 1'b1, "idle pins");
		rd(A_CTRL, {11'h000, CTRL_RST});
		wr(A_CMD, 16'h0007);
		rd(A_STAT, 16'h0000);
		rd(3'h5, 16'h0000);
	endtask
	task automatic s_full(input logic [4:0] c, input logic [11:0] v,
		input int nw);
		wr(A_CTRL, {11'h000, c});
		wr(A_CODE, {4'h0, v});
		run(CMD_FULL, nw, 1);
		chk(dac_q === v, "converter word");
		rd(A_LAST, {4'h0, v});
	endtask
	task automatic s_byte;
		wr(A_CTRL, 16'h0003);
		wr(A_CODE, 16'h02b4);
		run(CMD_HIGH, 1, 1);
		chk(dac_q === 12'h285, "high byte update");
		wr(A_CTRL, 16'h0001);
		wr(A_CODE, 16'h07e9);
		run(CMD_LOW, 2, 1);
		chk(dac_q === 12'h2e9, "low byte update");
		run(CMD_XFER, 1, 1);
		chk(dac_q === 12'h2e9, "transfer word");
	endtask
	// Code and command writes during a sequence must be refused
	task automatic s_busy;
		int w0;
		w0 = writes;
		wr(A_CTRL, 16'h0003);
		wr(A_CODE, 16'h04d2);
		wr(A_CMD, {13'h0000, CMD_FULL});
		wr(A_CODE, 16'h0111);
		wr(A_CMD, {13'h0000, CMD_XFER});
		wait_busy(1'b0);
		chk(writes - w0 == 2, "busy refusal");
		chk(dac_q === 12'h4d2, "code kept while busy");
		rd(A_CODE, 16'h04d2);
		rd(A_LAST, 16'h04d2);
	endtask
	task automatic ctl(input logic [15:0] c, input logic [11:0] e);
		wr(A_CTRL, c);
		rd(A_CTRL, c);
		chk(code_out === e, "presented code");
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(negedge mclk);
		s_reset();
		s_full(5'h03, 12'ha5c, 2);
		s_full(5'h07, 12'h3c1, 2);
		s_full(5'h00, 12'h9e7, 3);
		s_full(5'h04, 12'h185, 3);
		s_byte();
		ctl(16'h0019, 12'hfff);
		ctl(16'h0009, 12'h000);
		ctl(16'h0001, 12'h2e9);
		ctl(16'h0000, 12'h2e9);
		chk(fs === 1'b0 && fo_n === 1'b1, "left format pins");
		s_busy();
		conclude();
	end
endmodule // testbench
`default_nettype wire

// ---- verilog/dbl_host.sv ----
// Host controller driving a 12-bit byte-loaded converter over its pins.
// Assumes software issues commands via a simple strobe register port.
//
// Functional notes
// RL1 - High byte select low with write loads
// RL2 - Low byte select low with write loads
// RL3 - Override pin low forces zeros or ones
// RL4 - Override leaves DAC register contents intact
// RL5 - Format pin chooses left or right justify
// RL6 - Hold override pin high for normal loads; the pin follows CTRL bit 3 alone, and commands still run with it low
// RL7 - Bus bit 7 is MSB, bit 0 LSB
// RL8 - Load strobe with write loads DAC register
// RL9 - Write strobe qualifies every register load
// RL10 - Byte plus load strobe updates both registers
// RL11 - All selects high plus load transfers word
// RL12 - Right justify: top nibble in high-byte low nibble
// RL13 - Left justify: bottom nibble in low-byte top nibble
// RL14 - Automatic mode: second byte carries load strobe
// RL15 - Automatic mode single byte update: one write
// RL16 - Strobed mode: two byte writes then transfer
// RL17 - Shared load strobe may update many converters
// RL18 - Strobed single byte update: two writes
// RL19 - Either byte may be written first
// RL20 - Device latches when write strobe rises
`timescale 1ns/1ps
`default_nettype none
module dbl_host
	import dbl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [15:0] rdata,
	output logic busy,
	output logic high_byte_select_n,
	output logic low_byte_select_n,
	output logic dac_load_strobe_n,
	output logic wr_n,
	output logic [7:0] bus_data,
	output logic format_or_override_n,
	output logic format_select
);
	// ********************************
	// Sequencer state
	// ********************************
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_FIRST = 3'b001,
		S_SECOND = 3'b010,
		S_XFER = 3'b011,
		S_SINGLE = 3'b100
	} dbl_st_t;
	typedef struct packed {
		dbl_st_t st;
		logic [4:0] ctrl;
		logic [11:0] code;
		logic [2:0] cmd;
		logic [11:0] last;
		logic req;
		dbl_cycle_t cyc;
		logic [15:0] rd;
		logic fsel;
	} dbl_host_t;
	dbl_host_t s_r, s_nxt;

	dbl_cyc_if cif ();

	logic [7:0] hi_byte, lo_byte;
	logic busy_w;

	// Byte images of the code in the chosen justification
	always_comb begin
		if (s_r.ctrl[C_RJUST]) begin
			hi_byte = {NIB_PAD[3:0], s_r.code[11:8]}; // RL12
			lo_byte = s_r.code[7:0]; // RL12
		end else begin
			hi_byte = s_r.code[11:4]; // RL13
			lo_byte = {s_r.code[3:0], NIB_PAD[3:0]}; // RL13
		end
	end

	assign busy_w = (s_r.st != S_IDLE);

	function automatic dbl_cycle_t mk(input logic hi, input logic ld,
		input logic [7:0] h, input logic [7:0] l);
		dbl_cycle_t c;
		c.sel_high = hi; // RL1
		c.sel_low = ~hi; // RL2
		c.load = ld; // RL10
		c.data = hi ? h : l;
		return c;
	endfunction

	always_comb begin
		logic hi_first;
		hi_first = ~s_r.ctrl[C_LOFIRST]; // RL19
		s_nxt = s_r;
		s_nxt.rd = 16'h0000;
		if (rd_stb) begin
			case (addr)
				A_CTRL: s_nxt.rd = {11'h000, s_r.ctrl};
				A_CODE: s_nxt.rd = {4'h0, s_r.code};
				A_CMD: s_nxt.rd = {13'h0000, s_r.cmd};
				A_STAT: s_nxt.rd = {15'h0000, busy_w};
				A_LAST: s_nxt.rd = {4'h0, s_r.last};
				default: s_nxt.rd = 16'h0000;
			endcase
		end
		if (wr_stb) begin
			case (addr)
				A_CTRL: s_nxt.ctrl = wdata[4:0];
				A_CODE: if (!busy_w) s_nxt.code = wdata[11:0];
				default: ;
			endcase
		end
		// Shared pin comes from a flop: a mux on flop outputs could glitch
		s_nxt.fsel = s_nxt.ctrl[C_OVR] ? s_nxt.ctrl[C_OVRONES]
			: s_nxt.ctrl[C_RJUST]; // RL5 RL3
		case (s_r.st)
			S_IDLE: begin
				if (wr_stb && addr == A_CMD) begin
					s_nxt.cmd = wdata[2:0];
					s_nxt.req = 1'b1;
					case (wdata[2:0])
						CMD_FULL: begin
							s_nxt.cyc = mk(hi_first, 1'b0, hi_byte, lo_byte);
							s_nxt.st = S_FIRST;
						end
						CMD_HIGH: begin
							s_nxt.cyc = mk(1'b1, s_r.ctrl[C_AUTO], hi_byte, lo_byte); // RL15
							s_nxt.st = S_SINGLE;
						end
						CMD_LOW: begin
							s_nxt.cyc = mk(1'b0, s_r.ctrl[C_AUTO], hi_byte, lo_byte); // RL15
							s_nxt.st = S_SINGLE;
						end
						CMD_XFER: begin
							// Input register to DAC register, no byte selected
							s_nxt.cyc = '{sel_high: 1'b0, sel_low: 1'b0,
								load: 1'b1, data: 8'h00}; // RL11 RL17
							s_nxt.st = S_XFER;
						end
						default: s_nxt.req = 1'b0;
					endcase
				end
			end
			S_FIRST: begin
				if (cif.done) begin
					// Second byte carries the load in automatic mode
					s_nxt.cyc = mk(~hi_first, s_r.ctrl[C_AUTO], hi_byte,
						lo_byte); // RL14 RL8
					s_nxt.st = S_SECOND;
				end
			end
			S_SECOND: begin
				if (cif.done) begin
					if (s_r.ctrl[C_AUTO]) begin
						s_nxt.req = 1'b0;
						s_nxt.last = s_r.code;
						s_nxt.st = S_IDLE;
					end else begin
						s_nxt.cyc = '{sel_high: 1'b0, sel_low: 1'b0,
							load: 1'b1, data: 8'h00}; // RL16
						s_nxt.st = S_XFER;
					end
				end
			end
			S_SINGLE: begin
				if (cif.done) begin
					if (s_r.ctrl[C_AUTO]) begin
						s_nxt.req = 1'b0;
						s_nxt.last = s_r.code;
						s_nxt.st = S_IDLE;
					end else begin
						// Strobed mode: byte write then transfer
						s_nxt.cyc = '{sel_high: 1'b0, sel_low: 1'b0,
							load: 1'b1, data: 8'h00}; // RL18
						s_nxt.st = S_XFER;
					end
				end
			end
			S_XFER: begin
				if (cif.done) begin
					s_nxt.req = 1'b0;
					s_nxt.last = s_r.code;
					s_nxt.st = S_IDLE;
				end
			end
			default: s_nxt.st = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '{st: S_IDLE, ctrl: CTRL_RST, code: CODE_RST,
				cmd: 3'h0, last: CODE_RST, req: 1'b0,
				cyc: '{sel_high: 1'b0, sel_low: 1'b0, load: 1'b0,
				data: 8'h00}, rd: 16'h0000, fsel: CTRL_RST[C_RJUST]};
		end else begin
			s_r <= s_nxt;
		end
	end

	// ********************************
	// Pin outputs
	// ********************************
	assign cif.req = s_r.req;
	assign cif.cyc = s_r.cyc;
	assign rdata = s_r.rd;
	assign busy = busy_w;
	// Override pin stays high unless software asks for a forced code
	assign format_or_override_n = ~s_r.ctrl[C_OVR]; // RL6 RL3 RL4
	// Same pin picks justify when high and zeros/ones when low
	assign format_select = s_r.fsel; // RL5 RL3

	dbl_wr_engine u_eng (
		.mclk(mclk),
		.rst(rst),
		.cif(cif.eng),
		.high_byte_select_n(high_byte_select_n),
		.low_byte_select_n(low_byte_select_n),
		.dac_load_strobe_n(dac_load_strobe_n),
		.wr_n(wr_n),
		.bus_data(bus_data)
	);
endmodule // dbl_host
`default_nettype wire

// ---- verilog/dbl_wr_engine.sv ----
// One write cycle on the converter pins: setup, strobe low, hold.
// Assumes a request is held until done pulses.
`timescale 1ns/1ps
`default_nettype none
module dbl_wr_engine
	import dbl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	dbl_cyc_if.eng cif,
	output logic high_byte_select_n,
	output logic low_byte_select_n,
	output logic dac_load_strobe_n,
	output logic wr_n,
	output logic [7:0] bus_data
);
	typedef enum logic [1:0] {
		E_IDLE = 2'b00,
		E_SETUP = 2'b01,
		E_WR = 2'b10,
		E_HOLD = 2'b11
	} dbl_est_t;
	typedef struct packed {
		dbl_est_t st;
		logic [3:0] cnt;
		logic hs_n;
		logic ls_n;
		logic ld_n;
		logic wr_n;
		logic [7:0] d;
		logic done;
	} dbl_eng_t;
	dbl_eng_t s_r, s_nxt;

	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			E_IDLE: begin
				if (cif.req && !s_r.done) begin
					s_nxt.hs_n = ~cif.cyc.sel_high;
					s_nxt.ls_n = ~cif.cyc.sel_low;
					s_nxt.ld_n = ~cif.cyc.load;
					// MSB on bit 7, LSB on bit 0
					s_nxt.d = cif.cyc.data; // RL7
					s_nxt.cnt = SETUP_CNT;
					s_nxt.st = E_SETUP;
				end
			end
			E_SETUP: begin
				if (s_r.cnt <= 4'h1) begin
					// Every load is qualified by the write strobe
					s_nxt.wr_n = 1'b0; // RL9
					s_nxt.cnt = WR_CNT;
					s_nxt.st = E_WR;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			E_WR: begin
				if (s_r.cnt <= 4'h1) begin
					// Device latches on the rising write edge
					s_nxt.wr_n = 1'b1; // RL20
					s_nxt.cnt = HOLD_CNT;
					s_nxt.st = E_HOLD;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			E_HOLD: begin
				if (s_r.cnt <= 4'h1) begin
					s_nxt.hs_n = 1'b1;
					s_nxt.ls_n = 1'b1;
					s_nxt.ld_n = 1'b1;
					s_nxt.done = 1'b1;
					s_nxt.st = E_IDLE;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			default: s_nxt.st = E_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_r <= '{st: E_IDLE, cnt: 4'h0, hs_n: 1'b1, ls_n: 1'b1,
				ld_n: 1'b1, wr_n: 1'b1, d: 8'h00, done: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign cif.done = s_r.done;
	assign high_byte_select_n = s_r.hs_n;
	assign low_byte_select_n = s_r.ls_n;
	assign dac_load_strobe_n = s_r.ld_n;
	assign wr_n = s_r.wr_n;
	assign bus_data = s_r.d;
endmodule // dbl_wr_engine
`default_nettype wire
